// ==== include/mfr_pkg.sv ====
/*
  Constants, register map, status word layout and state codes of the
  multi-frame receive buffer block.
  Assumes a 100 MHz core clock and a 13.56 MHz carrier.
*/
// What this block does
// - Multi-frame reception runs only when its enable bit is set and transceive starts.
// - After each frame but the eighth the receiver is re-enabled automatically in multi-frame mode.
// - Receive buffer splits into 32-byte sub-buffers, at most 8 frames per cycle.
// - Frame n is stored at buffer address 32 times n, first frame at 0.
// - At most 28 payload bytes of a frame enter its sub-buffer.
// - Status word lands in bytes 28 to 31; gap bytes stay unwritten.
// - Status holds byte count, crc, short, collision, length flags, summary as OR.
// - Length fault when length byte exceeds 28 or fewer bytes arrive than announced.
// - Reserved status bits are written as zero.
// - Good crc, no collision and matching length store data with a clean status.
// - Bad crc with matching length stores data, sets summary and crc flags.
// - Length byte above 28 stores no payload, only a status with length fault.
// - Length byte up to 28 but above received count stores data and sets short frame flag.
// - Receive-done flag is set once for every received frame.
// - Frame count field is published at the end of reception.
// - After the eighth frame the block leaves and waits for the next send.
// - The idle command aborts the cycle and stops receiving.
// - Frame count field clears when a new reception cycle starts.
// - Receiver off-time between frames is at least 2 carrier cycles, under 2 us.
package mfr_pkg;
  // Register byte addresses
  localparam logic [8:0] MFR_CTRL_OFS    = 9'h000;
  localparam logic [8:0] MFR_CMD_OFS     = 9'h004;
  localparam logic [8:0] MFR_IRQ_OFS     = 9'h008;
  localparam logic [8:0] MFR_RXSTAT_OFS  = 9'h00c;
  localparam logic [8:0] MFR_BUF_BASE    = 9'h100;
  // Control and command bits
  localparam int MFR_CTRL_MULTI_BIT = 0;
  localparam int MFR_CMD_START_BIT  = 0;
  localparam int MFR_CMD_IDLE_BIT   = 1;
  localparam int MFR_IRQ_RXDONE_BIT = 0;
  // Receive status layout
  localparam int MFR_RXST_NUM_LSB  = 0;
  localparam int MFR_RXST_LIVE_LSB = 8;
  localparam int MFR_RXST_FSM_LSB  = 16;
  // Buffer geometry
  localparam int         MFR_SUB_BYTES   = 32;
  localparam int         MFR_MAX_FRAMES  = 8;
  localparam logic [7:0] MFR_MAX_PAYLOAD = 8'h1c;
  localparam logic [4:0] MFR_STAT_POS    = 5'h1c;
  localparam int         MFR_BUF_BYTES   = MFR_SUB_BYTES * MFR_MAX_FRAMES;
  // Status word fields
  localparam int MFR_ST_CNT_LSB  = 0;
  localparam int MFR_ST_SUM_BIT  = 8;
  localparam int MFR_ST_CRC_BIT  = 9;
  localparam int MFR_ST_SHRT_BIT = 10;
  localparam int MFR_ST_COLL_BIT = 11;
  localparam int MFR_ST_LEN_BIT  = 12;
  localparam int MFR_ST_RSV_LSB  = 13;
  // Reset values
  localparam logic [3:0] MFR_FRAMES_RST = 4'h0;
  // Re-arm gap: two carrier periods rounded up to core clock cycles
  localparam int         MFR_CLK_PS      = 10000;
  localparam int         MFR_CARRIER_PS  = 73746;
  localparam int         MFR_GAP_MAX_NS  = 2000;
  localparam int         MFR_REARM_CYC   = (2 * MFR_CARRIER_PS + MFR_CLK_PS - 1) / MFR_CLK_PS;
  localparam int         MFR_GAP_MAX_CYC = (MFR_GAP_MAX_NS * 1000) / MFR_CLK_PS;
  localparam logic [7:0] MFR_GAP_LOAD    = 8'(MFR_REARM_CYC - 2);

  typedef enum logic [4:0] {
    MFR_S_IDLE  = 5'h01,
    MFR_S_RECV  = 5'h02,
    MFR_S_STAT  = 5'h04,
    MFR_S_GAP   = 5'h08,
    MFR_S_AWAIT = 5'h10
  } mfr_state_t;
endpackage

// ==== include/mfr_buf_if.sv ====
/*
  Connection between the frame controller and the receive buffer memory.
  Assumes one clock shared by both ends.
*/
`timescale 1ns/1ps
interface mfr_buf_if;
  logic        byte_we;    // Payload byte write
  logic [7:0]  byte_addr;  // Payload byte address
  logic [7:0]  byte_data;  // Payload byte
  logic        word_we;    // Status word write
  logic [2:0]  word_idx;   // Sub-buffer of the status word
  logic [31:0] word_data;  // Status word
  logic        rd_en;      // Host word read
  logic [5:0]  rd_idx;     // Host word index
  logic [31:0] rd_data;    // Read word, one cycle after rd_en
  modport ctl (output byte_we, byte_addr, byte_data, word_we, word_idx, word_data, rd_en, rd_idx,
               input rd_data);
  modport mem (input byte_we, byte_addr, byte_data, word_we, word_idx, word_data, rd_en, rd_idx,
               output rd_data);
endinterface

// ==== hdl/mfr_rx_buf.sv ====
/*
  Receive buffer: byte writes for payload, word writes for status words,
  word reads for the host. Assumes synchronous single-clock use.
*/
`timescale 1ns/1ps
module mfr_rx_buf
  import mfr_pkg::*;
(
  input  wire logic core_clk_i,  // Core clock
  input  wire logic rst_n_i,     // Synchronised reset, active low
  mfr_buf_if.mem    bus          // Controller side
);
  typedef struct packed {
    logic [31:0] rdata;
  } mfr_buf_st_t;

  logic [7:0]  mem_q [MFR_BUF_BYTES];
  mfr_buf_st_t st_r;
  mfr_buf_st_t st_nxt;

  // Read word assembly, little endian
  always_comb
  begin
    st_nxt = st_r;
    if (bus.rd_en)
    begin
      for (int k = 0; k < 4; k++)
        st_nxt.rdata[8*k +: 8] = mem_q[{bus.rd_idx, 2'(k)}];
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      st_r <= '0;
    else
      st_r <= st_nxt;
  end

  // Memory writes; contents are not reset, unwritten bytes stay undefined
  always_ff @(posedge core_clk_i)
  begin
    if (bus.byte_we)
      mem_q[bus.byte_addr] <= bus.byte_data;
    if (bus.word_we)
    begin
      for (int k = 0; k < 4; k++)
        mem_q[{bus.word_idx, MFR_STAT_POS[4:2], 2'(k)}] <= bus.word_data[8*k +: 8];
    end
  end

  assign bus.rd_data = st_r.rdata;
endmodule

// ==== hdl/mfr_rx_top.sv ====
/*
  Multi-frame receive controller: collects timeslot responses into
  32-byte sub-buffers, writes status words, counts frames, re-arms the
  receiver. Assumes a byte stream from the demodulator synchronous to
  core_clk_i and a one-cycle register port from the host side.
*/
// Design decisions made here: the register addresses and strobed register access.
`timescale 1ns/1ps
module mfr_rx_top
  import mfr_pkg::*;
(
  input  wire logic        core_clk_i,      // 100 MHz core clock
  input  wire logic        resetn_i,        // Asynchronous reset, active low
  input  wire logic [8:0]  reg_addr_i,      // Register byte address
  input  wire logic [31:0] reg_wdata_i,     // Write data
  input  wire logic        reg_wr_i,        // Write strobe
  input  wire logic        reg_rd_i,        // Read strobe
  output logic      [31:0] reg_rdata_o,     // Read data, cycle after strobe
  input  wire logic        rx_byte_valid_i, // Demodulated byte valid
  input  wire logic [7:0]  rx_byte_i,       // Demodulated byte
  input  wire logic        rx_frame_end_i,  // End of frame pulse
  input  wire logic        rx_crc_ok_i,     // CRC result at frame end
  input  wire logic        rx_collision_i,  // Collision seen in frame
  output logic             rx_enable_o,     // Receiver enable
  output logic             rx_active_o      // Reception cycle in progress
);
  import mfr_pkg::*;

  typedef struct packed {
    mfr_state_t  fsm;
    logic        multi_en;
    logic        multi_on;
    logic [3:0]  frames;
    logic [3:0]  num_frames;
    logic        rx_done;
    logic [7:0]  rcv_cnt;
    logic [7:0]  len;
    logic        len_big;
    logic        crc_bad;
    logic        coll;
    logic [7:0]  gap;
    logic [31:0] rdata;
    logic        rd_buf;
    logic [7:0]  off_cnt;
  } mfr_top_st_t;

  logic        rst_meta_r;
  logic        rst_n_r;
  mfr_top_st_t st_r;
  mfr_top_st_t st_nxt;
  logic        cmd_start;
  logic        cmd_idle;
  logic        store_ok;
  logic        short_f;
  logic        len_f;
  logic        sum_f;
  logic [31:0] status_w;
  mfr_buf_if   buf_if ();

  // Buffer window decode
  function automatic logic in_buf(input logic [8:0] a);
    return a[8];
  endfunction

  // Register write to one offset
  function automatic logic wr_hit(input logic wr, input logic [8:0] a, input logic [8:0] ofs);
    return wr && a == ofs;
  endfunction

  // States in which no reception cycle runs
  function automatic logic is_rest(input mfr_state_t s);
    return s == MFR_S_IDLE || s == MFR_S_AWAIT;
  endfunction

  // Reset release through two flip-flops
  always_ff @(posedge core_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      rst_meta_r <= 1'b0;
      rst_n_r    <= 1'b0;
    end
    else
    begin
      rst_meta_r <= 1'b1;
      rst_n_r    <= rst_meta_r;
    end
  end

  // Command decode; idle wins over start
  assign cmd_idle  = wr_hit(reg_wr_i, reg_addr_i, MFR_CMD_OFS) && reg_wdata_i[MFR_CMD_IDLE_BIT];
  assign cmd_start = wr_hit(reg_wr_i, reg_addr_i, MFR_CMD_OFS) && reg_wdata_i[MFR_CMD_START_BIT] && !cmd_idle;

  // Payload kept only below byte 28 and while length byte allows it
  assign store_ok = rx_byte_valid_i && st_r.rcv_cnt < MFR_MAX_PAYLOAD
                    && ((st_r.rcv_cnt == 8'h00) ? rx_byte_i <= MFR_MAX_PAYLOAD : !st_r.len_big);

  // Status word of the finished frame
  assign short_f = !st_r.len_big && st_r.rcv_cnt < st_r.len;
  assign len_f   = st_r.len_big || st_r.rcv_cnt < st_r.len;
  assign sum_f   = st_r.crc_bad || short_f || st_r.coll;
  always_comb
  begin
    status_w = '0;
    status_w[MFR_ST_CNT_LSB +: 8] = st_r.rcv_cnt;
    status_w[MFR_ST_SUM_BIT]      = sum_f;
    status_w[MFR_ST_CRC_BIT]      = st_r.crc_bad;
    status_w[MFR_ST_SHRT_BIT]     = short_f;
    status_w[MFR_ST_COLL_BIT]     = st_r.coll;
    status_w[MFR_ST_LEN_BIT]      = len_f;
  end

  // Buffer port: payload at 32 * frames + byte index, status at bytes 28..31
  assign buf_if.byte_we   = st_r.fsm == MFR_S_RECV && store_ok;
  assign buf_if.byte_addr = {st_r.frames[2:0], st_r.rcv_cnt[4:0]};
  assign buf_if.byte_data = rx_byte_i;
  assign buf_if.word_we   = st_r.fsm == MFR_S_STAT;
  assign buf_if.word_idx  = st_r.frames[2:0];
  assign buf_if.word_data = status_w;
  assign buf_if.rd_en     = reg_rd_i && in_buf(reg_addr_i);
  assign buf_if.rd_idx    = reg_addr_i[7:2];

  mfr_rx_buf u_buf (
    .core_clk_i (core_clk_i),
    .rst_n_i    (rst_n_r),
    .bus        (buf_if.mem)
  );

  // Next-state logic: reception sequence and register file
  always_comb
  begin
    st_nxt       = st_r;
    st_nxt.rdata = '0;
    st_nxt.rd_buf = reg_rd_i && in_buf(reg_addr_i);
    // Cycles with the receiver off, saturating; feeds the re-arm gap check
    st_nxt.off_cnt = (st_r.fsm == MFR_S_RECV) ? 8'h00
                     : st_r.off_cnt + {7'h00, st_r.off_cnt != 8'hff};
    // Register writes
    if (wr_hit(reg_wr_i, reg_addr_i, MFR_CTRL_OFS))
      st_nxt.multi_en = reg_wdata_i[MFR_CTRL_MULTI_BIT];
    if (wr_hit(reg_wr_i, reg_addr_i, MFR_IRQ_OFS) && reg_wdata_i[MFR_IRQ_RXDONE_BIT])
      st_nxt.rx_done = 1'b0;
    // Register reads
    if (reg_rd_i && !in_buf(reg_addr_i))
    begin
      case (reg_addr_i)
        MFR_CTRL_OFS:   st_nxt.rdata[MFR_CTRL_MULTI_BIT] = st_r.multi_en;
        MFR_IRQ_OFS:    st_nxt.rdata[MFR_IRQ_RXDONE_BIT] = st_r.rx_done;
        MFR_RXSTAT_OFS:
        begin
          st_nxt.rdata[MFR_RXST_NUM_LSB +: 4]  = st_r.num_frames;
          st_nxt.rdata[MFR_RXST_LIVE_LSB +: 4] = st_r.frames;
          st_nxt.rdata[MFR_RXST_FSM_LSB +: 5]  = st_r.fsm;
        end
        default:        st_nxt.rdata = '0;
      endcase
    end
    // Frame sequencing
    case (st_r.fsm)
      MFR_S_IDLE, MFR_S_AWAIT:
      begin
        if (cmd_start)
        begin
          st_nxt.fsm        = MFR_S_RECV;
          st_nxt.multi_on   = st_r.multi_en;
          st_nxt.frames     = MFR_FRAMES_RST;
          st_nxt.num_frames = MFR_FRAMES_RST;
          st_nxt.rcv_cnt    = '0;
          st_nxt.len_big    = 1'b0;
          st_nxt.len        = '0;
        end
      end
      MFR_S_RECV:
      begin
        if (rx_byte_valid_i)
        begin
          if (st_r.rcv_cnt == 8'h00)
          begin
            st_nxt.len     = rx_byte_i;
            st_nxt.len_big = rx_byte_i > MFR_MAX_PAYLOAD;
          end
          if (st_r.rcv_cnt != 8'hff)
            st_nxt.rcv_cnt = st_r.rcv_cnt + 8'h01;
        end
        if (rx_frame_end_i)
        begin
          st_nxt.fsm     = MFR_S_STAT;
          st_nxt.crc_bad = !rx_crc_ok_i;
          st_nxt.coll    = rx_collision_i;
        end
      end
      MFR_S_STAT:
      begin
        st_nxt.frames  = st_r.frames + 4'h1;
        st_nxt.rcv_cnt = '0;
        st_nxt.len     = '0;
        st_nxt.len_big = 1'b0;
        st_nxt.gap     = MFR_GAP_LOAD;
        if (st_r.multi_on && st_r.frames < 4'(MFR_MAX_FRAMES - 1))
          st_nxt.fsm = MFR_S_GAP;
        else
        begin
          st_nxt.fsm        = MFR_S_AWAIT;
          st_nxt.num_frames = st_r.frames + 4'h1;
        end
      end
      MFR_S_GAP:
      begin
        if (st_r.gap == 8'h00)
          st_nxt.fsm = MFR_S_RECV;
        else
          st_nxt.gap = st_r.gap - 8'h01;
      end
      default: st_nxt.fsm = MFR_S_IDLE;
    endcase
    // Every status write is one received frame; set wins over a clear
    if (st_r.fsm == MFR_S_STAT)
      st_nxt.rx_done = 1'b1;
    // Abort: stop receiving, publish what was collected
    if (cmd_idle)
    begin
      st_nxt.fsm = MFR_S_IDLE;
      if (!is_rest(st_r.fsm))
        st_nxt.num_frames = (st_r.fsm == MFR_S_STAT) ? st_r.frames + 4'h1 : st_r.frames;
    end
  end

  // State register
  always_ff @(posedge core_clk_i or negedge rst_n_r)
  begin
    if (!rst_n_r)
    begin
      st_r     <= '0;
      st_r.fsm <= MFR_S_IDLE;
    end
    else
      st_r <= st_nxt;
  end

  // Outputs
  assign reg_rdata_o = st_r.rd_buf ? buf_if.rd_data : st_r.rdata;
  assign rx_enable_o = st_r.fsm == MFR_S_RECV;
  assign rx_active_o = !is_rest(st_r.fsm);

  // Checks
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rst_n_r);

  // Gap state only exists in multi-frame operation
  chk_gap_needs_multi: assert property (st_r.fsm == MFR_S_GAP |-> st_r.multi_on)
    else $error("gap state without multi-frame enable");
  // Single-frame operation ends after one frame
  chk_single_exit: assert property (st_r.fsm == MFR_S_STAT && !st_r.multi_on && !cmd_idle
    |=> st_r.fsm == MFR_S_AWAIT && st_r.num_frames == 4'h1)
    else $error("single frame did not end the cycle");

  // Receiver off for one status cycle plus the gap, then on again
  chk_rearm_gap: assert property (
    $fell(rx_enable_o) && $past(rx_frame_end_i) && st_r.multi_on && st_r.frames < 4'h7
    |-> (!rx_enable_o)[*8] ##1 (!rx_enable_o)[*7] ##1 (rx_enable_o || st_r.fsm == MFR_S_IDLE))
    else $error("receiver not re-armed after fifteen off cycles");
  // Status cycle steps the frame count and enters the gap
  chk_rearm_next: assert property (st_r.fsm == MFR_S_STAT && st_r.multi_on && st_r.frames < 4'h7 && !cmd_idle
    |=> st_r.fsm == MFR_S_GAP && st_r.frames == $past(st_r.frames) + 4'h1)
    else $error("no gap after a frame in multi-frame operation");
  // Off time between frames stays inside its window
  chk_gap_span: assert property ($rose(rx_enable_o) && st_r.frames != 4'h0
    |-> st_r.off_cnt >= 8'(MFR_REARM_CYC) && st_r.off_cnt <= 8'(MFR_GAP_MAX_CYC))
    else $error("receiver off time between frames out of range");

  // Payload lands in the current sub-buffer only
  chk_write_base: assert property (buf_if.byte_we |-> buf_if.byte_addr[7:5] == st_r.frames[2:0])
    else $error("payload written outside current sub-buffer");
  // Payload never reaches the status word
  chk_payload_cap: assert property (buf_if.byte_we |-> buf_if.byte_addr[4:0] < MFR_STAT_POS)
    else $error("payload byte written into status word area");
  // One status write per frame
  chk_stat_once: assert property (buf_if.word_we |=> !buf_if.word_we)
    else $error("status word written twice in a row");
  // Reserved status bits
  chk_status_rsv: assert property (buf_if.word_we |-> buf_if.word_data[31:MFR_ST_RSV_LSB] == '0)
    else $error("reserved status bits not zero");

  // Summary flag is the OR of the three error flags
  chk_summary_or: assert property (buf_if.word_we |-> buf_if.word_data[MFR_ST_SUM_BIT] ==
    (buf_if.word_data[MFR_ST_CRC_BIT] | buf_if.word_data[MFR_ST_SHRT_BIT] | buf_if.word_data[MFR_ST_COLL_BIT]))
    else $error("summary flag differs from OR of error flags");
  // Collision at frame end reaches the status word
  chk_coll_status: assert property (st_r.fsm == MFR_S_RECV && rx_frame_end_i && rx_collision_i && !cmd_idle
    |=> buf_if.word_we && buf_if.word_data[MFR_ST_COLL_BIT] && buf_if.word_data[MFR_ST_SUM_BIT])
    else $error("collision missing from status word");
  // Good frame of matching length gives a clean status
  chk_clean_status: assert property (st_r.fsm == MFR_S_RECV && rx_frame_end_i && rx_crc_ok_i
    && !rx_collision_i && !cmd_idle && !st_r.len_big && st_r.rcv_cnt + {7'h00, rx_byte_valid_i} == st_r.len
    |=> buf_if.word_we && buf_if.word_data[MFR_ST_LEN_BIT:MFR_ST_SUM_BIT] == 5'h00)
    else $error("error flag set for a clean frame");
  // Bad CRC raises the crc and summary flags
  chk_crc_status: assert property (st_r.fsm == MFR_S_RECV && rx_frame_end_i && !rx_crc_ok_i && !cmd_idle
    |=> buf_if.word_we && buf_if.word_data[MFR_ST_CRC_BIT] && buf_if.word_data[MFR_ST_SUM_BIT])
    else $error("crc failure missing from status word");

  // First byte of a frame is kept as its length
  chk_len_latch: assert property (st_r.fsm == MFR_S_RECV && rx_byte_valid_i && st_r.rcv_cnt == 8'h00
    |=> st_r.len == $past(rx_byte_i))
    else $error("length byte not captured");
  // Oversize length byte marks the frame
  chk_len_status: assert property (st_r.fsm == MFR_S_RECV && rx_byte_valid_i && st_r.rcv_cnt == 8'h00
    && rx_byte_i > MFR_MAX_PAYLOAD |=> st_r.len_big)
    else $error("oversize length byte without length fault");
  // Oversize frame stores nothing
  chk_len_drop: assert property (st_r.len_big |-> !buf_if.byte_we)
    else $error("payload stored despite oversize length byte");
  // Short frame sets short, length and summary flags
  chk_short_status: assert property (buf_if.word_we && !st_r.len_big && st_r.rcv_cnt < st_r.len
    |-> buf_if.word_data[MFR_ST_SHRT_BIT] && buf_if.word_data[MFR_ST_LEN_BIT] && buf_if.word_data[MFR_ST_SUM_BIT])
    else $error("short frame not flagged");

  // Receive-done follows every status write
  chk_done_flag: assert property (st_r.fsm == MFR_S_STAT |=> st_r.rx_done)
    else $error("receive-done not set after frame");
  // Eighth frame ends the cycle
  chk_eighth_exit: assert property (st_r.fsm == MFR_S_STAT && st_r.frames == 4'h7 && !cmd_idle
    |=> st_r.fsm == MFR_S_AWAIT && st_r.num_frames == 4'h8)
    else $error("no exit to await state after eighth frame");
  // Abort in the gap publishes the frames collected
  chk_abort_publish: assert property (st_r.fsm == MFR_S_GAP && cmd_idle
    |=> st_r.num_frames == $past(st_r.frames))
    else $error("frame count not published on abort");
  // Idle command stops reception
  chk_idle_stop: assert property (cmd_idle |=> !rx_enable_o && st_r.fsm == MFR_S_IDLE)
    else $error("idle command did not stop reception");
  // New cycle clears both counts
  chk_count_clear: assert property (is_rest(st_r.fsm) && cmd_start
    |=> st_r.frames == 4'h0 && st_r.num_frames == 4'h0)
    else $error("frame count not cleared at cycle start");
  // Counts never pass eight
  chk_count_range: assert property (st_r.frames <= 4'h8 && st_r.num_frames <= 4'h8)
    else $error("frame count beyond eight");

  // Main scenarios
  cov_eight_frames: cover property (st_r.fsm == MFR_S_STAT && st_r.frames == 4'h7 && st_r.multi_on);
  cov_idle_abort: cover property (st_r.fsm == MFR_S_GAP && cmd_idle);
  cov_len_fault: cover property (buf_if.word_we && buf_if.word_data[MFR_ST_LEN_BIT]);
  cov_crc_fault: cover property (buf_if.word_we && buf_if.word_data[MFR_ST_CRC_BIT] && !short_f);
  cov_single_frame: cover property (st_r.fsm == MFR_S_STAT && !st_r.multi_on);
endmodule

// ==== testbench/mfr_card_model.sv ====
/*
  Card side model: answers one timeslot frame per send call.
  Assumes the bench calls send and that it shares core_clk_i.
*/
`timescale 1ns/1ps
module mfr_card_model (
  input  wire logic       clk_i,    // Core clock
  input  wire logic       rx_en_i,  // Receiver enable from the block
  output logic            valid_o,  // Byte strobe
  output logic      [7:0] byte_o,   // Byte value
  output logic            end_o,    // End of frame
  output logic            crc_o,    // CRC result
  output logic            coll_o    // Collision seen
);
  initial
  begin
    valid_o = 1'b0;
    byte_o  = 8'h00;
    end_o   = 1'b0;
    crc_o   = 1'b0;
    coll_o  = 1'b0;
  end

  // Sends len first, then a tag pattern; slow delays the answer
  task automatic send(input logic [7:0] len, input logic [7:0] n, input logic [7:0] tag,
                      input logic crc, input logic coll, input int slow);
    int i;
    begin
      i = 0;
      do
      begin
        @(posedge clk_i);
        #1;
        i++;
      end
      while (rx_en_i !== 1'b1 && i < 400);
      repeat (slow) @(posedge clk_i);
      for (i = 0; i < n; i++)
      begin
        byte_o  <= (i == 0) ? len : 8'(tag + i * 7);
        valid_o <= 1'b1;
        end_o   <= (i == n - 1);
        crc_o   <= crc;
        coll_o  <= coll;
        @(posedge clk_i);
      end
      // Released lines do not keep the last value
      valid_o <= 1'b0;
      end_o   <= 1'b0;
      byte_o  <= ~byte_o;
      crc_o   <= ~crc;
      coll_o  <= ~coll;
    end
  endtask
endmodule

// ==== testbench/mfr_rx_top_bench.sv ====
/*
  Self-checking bench of the multi-frame receive block.
  Assumes the card model and the register port of the notes.
*/
`timescale 1ns/1ps
module mfr_rx_top_bench;
  import mfr_pkg::*;
  logic        core_clk_i, resetn_i, reg_wr_i, reg_rd_i;
  logic [8:0]  reg_addr_i;
  logic [31:0] reg_wdata_i, reg_rdata_o, d;
  logic        bv, fe, crc, coll, rx_enable_o, rx_active_o;
  logic [7:0]  bd;
  logic [7:0]  lens[8], ns[8], tags[8];
  logic        crcs[8], colls[8];
  int          mismatches, n_checks, g;

  mfr_rx_top uut (.core_clk_i(core_clk_i), .resetn_i(resetn_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
    .rx_byte_valid_i(bv), .rx_byte_i(bd), .rx_frame_end_i(fe), .rx_crc_ok_i(crc),
    .rx_collision_i(coll), .rx_enable_o(rx_enable_o), .rx_active_o(rx_active_o));
  mfr_card_model card (.clk_i(core_clk_i), .rx_en_i(rx_enable_o), .valid_o(bv), .byte_o(bd),
    .end_o(fe), .crc_o(crc), .coll_o(coll));

  // Clock
  always #5 core_clk_i = ~core_clk_i;

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp)
    begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic wr(input logic [8:0] a, input logic [31:0] v);
    @(posedge core_clk_i);
    reg_addr_i  <= a;
    reg_wdata_i <= v;
    reg_wr_i    <= 1'b1;
    @(posedge core_clk_i);
    reg_wr_i    <= 1'b0;
  endtask

  task automatic rd(input logic [8:0] a);
    @(posedge core_clk_i);
    reg_addr_i <= a;
    reg_rd_i   <= 1'b1;
    @(posedge core_clk_i);
    reg_rd_i   <= 1'b0;
    #1 d = reg_rdata_o;
  endtask

  // Status word expected from what the card sent
  function automatic logic [31:0] exp_stat(input int k);
    logic sh, cf;
    sh = (ns[k] < lens[k]) && (lens[k] <= MFR_MAX_PAYLOAD);
    cf = !crcs[k];
    exp_stat = 32'h0;
    exp_stat[MFR_ST_CNT_LSB +: 8] = ns[k];
    exp_stat[MFR_ST_SUM_BIT]  = cf | sh | colls[k];
    exp_stat[MFR_ST_CRC_BIT]  = cf;
    exp_stat[MFR_ST_SHRT_BIT] = sh;
    exp_stat[MFR_ST_COLL_BIT] = colls[k];
    exp_stat[MFR_ST_LEN_BIT]  = (lens[k] > MFR_MAX_PAYLOAD) || (ns[k] < lens[k]);
  endfunction

  // Status word and stored payload of one sub-buffer; gap bytes are skipped
  task automatic check_frame(input int k);
    rd(MFR_BUF_BASE + 9'(32 * k + 28));
    chk("status", exp_stat(k), d);
    if (lens[k] <= MFR_MAX_PAYLOAD)
      for (int i = 0; i < ns[k] && i < 28; i++)
      begin
        rd(MFR_BUF_BASE + 9'(32 * k + (i & ~3)));
        chk("payload", {24'h0, (i == 0) ? lens[k] : 8'(tags[k] + i * 7)},
            {24'h0, d[8 * (i % 4) +: 8]});
      end
  endtask

  // Sends frame k and records what was sent
  task automatic frame(input int k, input logic [7:0] len, input logic [7:0] n, input logic c, input logic cl);
    lens[k] = len;
    ns[k] = n;
    crcs[k] = c;
    colls[k] = cl;
    tags[k] = 8'($urandom);
    card.send(len, n, tags[k], c, cl, $urandom % 4);
  endtask

  initial
  begin
    #500000;
    mismatches++;
    give_verdict();
  end

  initial
  begin
    core_clk_i = 1'b0;
    resetn_i = 1'b0;
    reg_wr_i = 1'b0;
    reg_rd_i = 1'b0;
    reg_addr_i = 9'h000;
    reg_wdata_i = 32'h0;
    mismatches = 0;
    n_checks = 0;
    void'($urandom(43927));
    repeat (3) @(posedge core_clk_i);
    resetn_i <= 1'b1;
    repeat (3) @(posedge core_clk_i);
    rd(MFR_RXSTAT_OFS);
    chk("rxstat reset", 32'h00010000, d);
    rd(9'h010);
    chk("unmapped", 32'h0, d);
    // Eight frames in multi mode, corner cases first
    wr(MFR_CTRL_OFS, 32'h1);
    wr(MFR_CMD_OFS, 32'h1);
    for (int k = 0; k < 8; k++)
    begin
      case (k)
        0: frame(k, 8'h1c, 8'h1c, 1'b1, 1'b0);
        1: frame(k, 8'h0c, 8'h0c, 1'b0, 1'b0);
        2: frame(k, 8'h1e, 8'h1e, 1'b1, 1'b0);
        3: frame(k, 8'h0a, 8'h05, 1'b1, 1'b0);
        4: frame(k, 8'h06, 8'h06, 1'b1, 1'b1);
        default:
        begin
          g = 1 + $urandom % 28;
          frame(k, 8'(g), 8'(g), 1'($urandom), 1'($urandom));
        end
      endcase
      // Look after the frame-end edge has updated the block
      g = 0;
      #1;
      while (rx_enable_o !== 1'b1 && g < 300)
      begin
        @(posedge core_clk_i);
        #1 g++;
      end
      if (k < 7)
        chk("rearm gap", 32'h1, {31'h0, g >= MFR_REARM_CYC && g <= MFR_GAP_MAX_CYC});
      rd(MFR_IRQ_OFS);
      chk("rx done", 32'h1, d);
      wr(MFR_IRQ_OFS, 32'h1);
    end
    chk("enable off", 32'h0, {31'h0, rx_enable_o});
    rd(MFR_RXSTAT_OFS);
    chk("rxstat full", 32'h00100008, d & 32'h001f000f);
    for (int k = 0; k < 8; k++)
      check_frame(k);
    wr(MFR_BUF_BASE + 9'h01c, 32'hffffffff);
    check_frame(0);
    // New cycle clears the count, then idle aborts it
    wr(MFR_CMD_OFS, 32'h1);
    rd(MFR_RXSTAT_OFS);
    chk("rxstat new", 32'h00020000, d & 32'h001f000f);
    frame(0, 8'h04, 8'h04, 1'b1, 1'b0);
    repeat (20) @(posedge core_clk_i);
    wr(MFR_CMD_OFS, 32'h2);
    rd(MFR_RXSTAT_OFS);
    chk("rxstat abort", 32'h00010001, d & 32'h001f000f);
    chk("active off", 32'h0, {31'h0, rx_active_o | rx_enable_o});
    check_frame(0);
    // Single frame with multi mode off
    wr(MFR_CTRL_OFS, 32'h0);
    wr(MFR_CMD_OFS, 32'h1);
    frame(0, 8'h07, 8'h07, 1'b1, 1'b0);
    repeat (20) @(posedge core_clk_i);
    rd(MFR_RXSTAT_OFS);
    chk("rxstat single", 32'h00100001, d & 32'h001f000f);
    check_frame(0);
    give_verdict();
  end
endmodule
